// File: fram_cmd_regs.svh
// named constants for the serial memory command front end
`ifndef FRAM_CMD_REGS_SVH
`define FRAM_CMD_REGS_SVH

// opcodes
`define OP_REG_READ          8'h65
`define OP_WRITE             8'h02
`define OP_DDR_QUAD_WRITE    8'hDE
`define OP_FAST_WRITE        8'hDA
`define OP_DDR_FAST_WRITE    8'hDD
`define OP_DUAL_DATA_WRITE   8'hA2
`define OP_DUAL_IO_WRITE     8'hA1
`define OP_QUAD_DATA_WRITE   8'h32
`define OP_QUAD_IO_WRITE     8'hD2
`define OP_DDR_QUAD_IO_WRITE 8'hD1

// continuation mode byte patterns
`define XIP_MASK             8'hF0
`define XIP_SDR_CODE         8'hA0
`define XIP_DDR_CODE         8'hA5

// address layout
`define ARRAY_ADDR_W         21
`define ADDR_LAST_BYTE       2'h2
`define REG_VOL_PAGE         8'h07

// bits per byte and lane widths
`define BYTE_BITS            4'h8
`define LANES_1              3'h1
`define LANES_2              3'h2
`define LANES_4              3'h4

// register latency code positions in the latency config register
`define RLC_LO_BIT           0
`define RLC_HI_BIT           1
`define DUMMY_CODE0          4'h0
`define DUMMY_CODE1          4'h1
`define DUMMY_CODE2          4'h2
`define DUMMY_CODE3          4'h3

`endif

// File: fram_cmd_pkg.sv
// types shared by the serial memory command front end
package fram_cmd_pkg;
  // command phase, one-hot
  typedef enum logic [6:0] {
    ST_OPC    = 7'h01,
    ST_ADDR   = 7'h02,
    ST_MODE   = 7'h04,
    ST_DUMMY  = 7'h08,
    ST_WDATA  = 7'h10,
    ST_RDOUT  = 7'h20,
    ST_IGNORE = 7'h40
  } state_t;

  typedef logic [2:0] lanes_t;   // active data lines: 1, 2 or 4
endpackage

// File: wr_buf_if.sv
// write request channel between the command decoder and the write buffer
`timescale 1ns/1ns
interface wr_buf_if;
  logic        valid;   // write request present
  logic        ready;   // buffer can take it
  logic [20:0] addr;    // array byte address
  logic [7:0]  data;    // byte to store

  modport src (output valid, output addr, output data, input ready);
  modport snk (input valid, input addr, input data, output ready);
endinterface

// File: wr_buf.sv
// two-entry write buffer with registered outputs
`timescale 1ns/1ns
module wr_buf (
  input  wire logic  clk,       // system clock
  input  wire logic  reset,     // synchronous reset, active high
  wr_buf_if.snk      in_ch,     // requests from the decoder
  output logic       out_valid, // request toward the array
  input  wire logic  out_ready, // array takes the request
  output logic [20:0] out_addr, // array address
  output logic [7:0] out_data   // array data
);
  logic [1:0]  cnt_r;     // entries held
  logic [20:0] spare_addr_r;  // second entry address
  logic [7:0]  spare_data_r;  // second entry data
  logic        push;      // entry accepted
  logic        pop;       // entry drained

  assign push = in_ch.valid & in_ch.ready;
  assign pop  = out_valid & out_ready;

  // ready is a flop so the decoder sees a clean level
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_r         <= 2'h0;
      out_valid     <= 1'b0;
      out_addr      <= 21'h000000;
      out_data      <= 8'h00;
      spare_addr_r  <= 21'h000000;
      spare_data_r  <= 8'h00;
      in_ch.ready   <= 1'b1;
    end else begin
      case (cnt_r)
        2'h0: begin
          if (push) begin
            out_valid <= 1'b1;
            out_addr  <= in_ch.addr;
            out_data  <= in_ch.data;
            cnt_r     <= 2'h1;
          end
        end
        2'h1: begin
          if (push && pop) begin
            out_addr <= in_ch.addr;
            out_data <= in_ch.data;
          end else if (pop) begin
            out_valid <= 1'b0;
            cnt_r     <= 2'h0;
          end else if (push) begin
            spare_addr_r <= in_ch.addr;
            spare_data_r <= in_ch.data;
            cnt_r        <= 2'h2;
            in_ch.ready  <= 1'b0;
          end
        end
        2'h2: begin
          // full: no push possible, drain the spare forward
          if (pop) begin
            out_addr    <= spare_addr_r;
            out_data    <= spare_data_r;
            cnt_r       <= 2'h1;
            in_ch.ready <= 1'b1;
          end
        end
        default: begin
          cnt_r <= 2'h0;
        end
      endcase
    end
  end
endmodule

// File: fram_cmd.sv
// command front end: register read and memory write decoding over serial lines
`timescale 1ns/1ns
`include "fram_cmd_regs.svh"

// How it works
// R1: register read: opcode, 3 address bytes, dummies, byte
// R2: host raises select after the register byte
// R3: bytes after the first register byte are undefined
// R4: register read returns the volatile copy
// R5: dummy count follows latency code bits
// R6: writes run at bus speed, unlimited burst; here a byte refused by the full write buffer is dropped
// R7: host sends opcode, address, optional mode byte
// R8: decode 21-bit address, ignore top three bits
// R9: data follows address or mode without gap
// R10: protected block: keep counting, discard data
// R11: burst starting protected behaves the same
// R12: partial byte at interruption is dropped
// R13: decode 02, DE, DA, DD writes
// R14: decode A2 dual data, A1 dual io
// R15: decode 32 quad data, D2, D1 quad io
// R16: writes in single, extended, dual, quad, SDR/DDR
// R17: plain write width follows bus mode
// R18: select held: address increments per byte
// R19: address wraps from top to zero
// R20: write only with write-enable latch set
// R21: completed write leaves latch set
// R22: latch clear: consume cycles, change nothing
// R23: select high ends burst, drops address
module fram_cmd
  import fram_cmd_pkg::*;
(
  input  wire logic        clk,                // system clock, 25 MHz
  input  wire logic        reset,              // synchronous reset, active high
  input  wire logic        cs_n,               // chip select pin, active low
  input  wire logic        sck,                // serial clock pin
  input  wire logic [3:0]  io_in,              // data lines in, io0 is the serial input
  output logic      [3:0]  io_out,             // data lines out, io1 is the serial output
  output logic      [3:0]  io_oe,              // high while a line is driven
  input  wire logic        dual_wide_mode,     // all phases on two lines unless quad_wide_mode is also set
  input  wire logic        quad_wide_mode,     // all phases on four lines
  input  wire logic        write_enable_latch, // array writes allowed
  input  wire logic [7:0]  latency_config_reg, // holds register latency code
  input  wire logic        protect_en,         // block protection active
  input  wire logic [20:0] protect_lo,         // first protected address
  input  wire logic [20:0] protect_hi,         // last protected address
  output logic      [23:0] reg_rd_addr,        // volatile register address
  input  wire logic [7:0]  reg_rd_data,        // register content for reg_rd_addr
  output logic             mem_wr_valid,       // array write request
  input  wire logic        mem_wr_ready,       // array accepts request
  output logic      [20:0] mem_wr_addr,        // array write address
  output logic      [7:0]  mem_wr_data,        // array write data
  output logic             write_dropped,      // pulse: byte lost to full buffer
  output logic             xip_active,         // next frame skips the opcode
  output logic             busy                // select seen active
);

  // lanes in use for a phase; a wide bus mode overrides per-command widths
  function automatic lanes_t lanes_for(input logic [7:0] op, input logic data_ph,
                                       input lanes_t bus_w);
    lanes_t w;
    w = `LANES_1;
    if (bus_w != `LANES_1) begin
      w = bus_w;                                                   // see R17
    end else begin
      case (op)
        `OP_DUAL_DATA_WRITE:   w = data_ph ? `LANES_2 : `LANES_1;  // see R14
        `OP_DUAL_IO_WRITE:     w = `LANES_2;                       // see R14
        `OP_QUAD_DATA_WRITE:   w = data_ph ? `LANES_4 : `LANES_1;  // see R15
        `OP_QUAD_IO_WRITE:     w = `LANES_4;                       // see R15
        `OP_DDR_QUAD_IO_WRITE: w = `LANES_4;                       // see R15
        default:               w = `LANES_1;
      endcase
    end
    return w;
  endfunction
  // shift the sampled lanes in, most significant bit first
  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic [3:0] io,
                                          input lanes_t w);
    logic [7:0] r;
    case (w)
      `LANES_4: r = {sh[3:0], io};
      `LANES_2: r = {sh[5:0], io[1:0]};
      default:  r = {sh[6:0], io[0]};
    endcase
    return r;
  endfunction
  // memory write opcodes
  function automatic logic is_write(input logic [7:0] op);
    return (op == `OP_WRITE) || (op == `OP_DDR_QUAD_WRITE) ||             // see R13
           (op == `OP_FAST_WRITE) || (op == `OP_DDR_FAST_WRITE) ||
           (op == `OP_DUAL_DATA_WRITE) || (op == `OP_DUAL_IO_WRITE) ||   // see R14
           (op == `OP_QUAD_DATA_WRITE) || (op == `OP_QUAD_IO_WRITE) ||   // see R15
           (op == `OP_DDR_QUAD_IO_WRITE);
  endfunction
  // opcodes that move address and data on both clock edges
  function automatic logic is_ddr(input logic [7:0] op);
    return (op == `OP_DDR_QUAD_WRITE) || (op == `OP_DDR_FAST_WRITE) ||
           (op == `OP_DDR_QUAD_IO_WRITE);                                 // see R16
  endfunction
  // opcodes that carry a mode byte; the plain and DDR quad writes do not
  function automatic logic has_mode(input logic [7:0] op);
    return is_write(op) && (op != `OP_WRITE) && (op != `OP_DDR_QUAD_WRITE);
  endfunction
  // address inside the protected window
  function automatic logic is_protected(input logic [20:0] a);
    return protect_en && (a >= protect_lo) && (a <= protect_hi);
  endfunction
  // pin synchronisers: two flops before any logic looks at a pin
  logic       cs_n_s1_r, cs_n_s2_r;    // select sync stages
  logic       sck_s1_r, sck_s2_r;      // clock sync stages
  logic       sck_d_r;                 // previous synced clock, for edges
  logic [3:0] io_s1_r, io_s2_r;        // data sync stages

  // sck and io share latency, so data sampled on an edge is aligned
  always_ff @(posedge clk) begin
    if (reset) begin
      cs_n_s1_r <= 1'b1;
      cs_n_s2_r <= 1'b1;
      sck_s1_r  <= 1'b0;
      sck_s2_r  <= 1'b0;
      sck_d_r   <= 1'b0;
      io_s1_r   <= 4'h0;
      io_s2_r   <= 4'h0;
    end else begin
      cs_n_s1_r <= cs_n;
      cs_n_s2_r <= cs_n_s1_r;
      sck_s1_r  <= sck;
      sck_s2_r  <= sck_s1_r;
      sck_d_r   <= sck_s2_r;
      io_s1_r   <= io_in;
      io_s2_r   <= io_s1_r;
    end
  end
  // frame state
  state_t      state_r;       // command phase
  logic [7:0]  op_r;          // current opcode
  lanes_t      w_r;           // lanes for the current phase
  logic        ddr_r;         // sample on both edges
  logic [7:0]  sh_r;          // input shifter
  logic [3:0]  cnt_r;         // bits held in the shifter
  logic [1:0]  abyte_r;       // address bytes received
  logic [23:0] addr_r;        // assembled address
  logic [20:0] wr_addr_r;     // burst write address
  logic [3:0]  dcnt_r;        // dummy cycles counted
  logic        xip_r;         // continuation armed
  logic [7:0]  xip_op_r;      // opcode replayed in continuation
  logic [7:0]  out_sh_r;      // output shifter
  logic        first_out_r;   // next fall loads the register byte
  logic        cs_act;        // select active
  logic        sck_rise;      // rising edge seen
  logic        sck_fall;      // falling edge seen
  logic        in_phase;      // a phase that shifts input
  logic        samp;          // take a sample now
  logic [7:0]  sh_nxt;        // shifter after this sample
  logic [3:0]  cnt_sum;       // bit count after this sample
  logic        byte_done;     // a whole byte just arrived
  lanes_t      bus_w;         // lanes set by the bus mode
  logic [3:0]  dummy_n;       // dummy cycles for register read
  logic [7:0]  rd_src;        // byte feeding the output shifter
  wr_buf_if    wch ();        // decoder to buffer channel
  assign cs_act   = ~cs_n_s2_r;
  assign sck_rise = sck_s2_r & ~sck_d_r;
  assign sck_fall = ~sck_s2_r & sck_d_r;
  assign bus_w    = quad_wide_mode ? `LANES_4 : (dual_wide_mode ? `LANES_2 : `LANES_1);
  assign in_phase = (state_r == ST_OPC) || (state_r == ST_ADDR) ||
                    (state_r == ST_MODE) || (state_r == ST_WDATA);
  // DDR phases also take the falling edge; the opcode is always on rising
  assign samp     = cs_act && in_phase &&
                    (sck_rise || (ddr_r && sck_fall && state_r != ST_OPC));  // see R16
  assign sh_nxt   = shift_in(sh_r, io_s2_r, w_r);
  assign cnt_sum  = cnt_r + {1'b0, w_r};
  assign byte_done = samp && (cnt_sum == `BYTE_BITS);
  assign rd_src   = first_out_r ? reg_rd_data : out_sh_r;
  // dummy count picked from the two latency code bits
  always_comb begin
    case ({latency_config_reg[`RLC_HI_BIT], latency_config_reg[`RLC_LO_BIT]})  // see R5
      2'h0:    dummy_n = `DUMMY_CODE0;
      2'h1:    dummy_n = `DUMMY_CODE1;
      2'h2:    dummy_n = `DUMMY_CODE2;
      default: dummy_n = `DUMMY_CODE3;
    endcase
  end
  // input shifter and bit count; a partial byte dies with the frame
  always_ff @(posedge clk) begin
    if (reset || !cs_act) begin
      sh_r  <= 8'h00;
      cnt_r <= 4'h0;                                   // see R12
    end else if (byte_done) begin
      sh_r  <= sh_nxt;
      cnt_r <= 4'h0;
    end else if (samp) begin
      sh_r  <= sh_nxt;
      cnt_r <= cnt_sum;
    end
  end
  // phase sequencing; select high restarts, replaying the opcode when armed
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= ST_OPC;
      w_r     <= `LANES_1;
      ddr_r   <= 1'b0;
      abyte_r <= 2'h0;
      dcnt_r  <= 4'h0;
    end else if (!cs_act) begin
      state_r <= xip_r ? ST_ADDR : ST_OPC;                             // see R23
      w_r     <= xip_r ? lanes_for(xip_op_r, 1'b0, bus_w) : bus_w;
      ddr_r   <= xip_r && is_ddr(xip_op_r);
      abyte_r <= 2'h0;
      dcnt_r  <= 4'h0;
    end else begin
      case (state_r)
        ST_OPC: begin
          if (byte_done) begin
            ddr_r <= is_ddr(sh_nxt);
            w_r   <= lanes_for(sh_nxt, 1'b0, bus_w);
            // unknown opcodes are swallowed until select rises
            state_r <= (is_write(sh_nxt) || sh_nxt == `OP_REG_READ) ? ST_ADDR
                                                                     : ST_IGNORE;
          end
        end
        ST_ADDR: begin
          if (byte_done) begin
            abyte_r <= abyte_r + 2'h1;
            if (abyte_r == `ADDR_LAST_BYTE) begin
              if (op_r == `OP_REG_READ) begin
                state_r <= (dummy_n == 4'h0) ? ST_RDOUT : ST_DUMMY;    // see R1
              end else if (has_mode(op_r)) begin
                state_r <= ST_MODE;                                    // see R7
              end else begin
                state_r <= ST_WDATA;                                   // see R9
                w_r     <= lanes_for(op_r, 1'b1, bus_w);
              end
            end
          end
        end
        ST_MODE: begin
          if (byte_done) begin
            state_r <= ST_WDATA;                                       // see R9
            w_r     <= lanes_for(op_r, 1'b1, bus_w);
          end
        end
        ST_DUMMY: begin
          if (sck_rise) begin
            dcnt_r <= dcnt_r + 4'h1;
            if (dcnt_r + 4'h1 == dummy_n) begin
              state_r <= ST_RDOUT;                                     // see R5
            end
          end
        end
        ST_WDATA:  state_r <= ST_WDATA;   // runs until select rises, see R6
        ST_RDOUT:  state_r <= ST_RDOUT;
        ST_IGNORE: state_r <= ST_IGNORE;
        default:   state_r <= ST_OPC;
      endcase
    end
  end
  // opcode capture and continuation arming from the mode byte
  always_ff @(posedge clk) begin
    if (reset) begin
      op_r     <= 8'h00;
      xip_r    <= 1'b0;
      xip_op_r <= 8'h00;
    end else if (!cs_act) begin
      op_r <= xip_op_r;   // only used when the frame skips the opcode
    end else if (byte_done && state_r == ST_OPC) begin
      op_r <= sh_nxt;                                                  // see R13
    end else if (byte_done && state_r == ST_MODE) begin
      // DDR fast write needs the full pattern, the others the high nibble
      xip_op_r <= op_r;
      if (op_r == `OP_DDR_FAST_WRITE) begin
        xip_r <= (sh_nxt == `XIP_DDR_CODE);
      end else begin
        xip_r <= ((sh_nxt & `XIP_MASK) == `XIP_SDR_CODE);
      end
    end
  end
  // address assembly and the burst counter; the burst counter holds with the latch clear
  always_ff @(posedge clk) begin
    if (reset) begin
      addr_r      <= 24'h000000;
      wr_addr_r   <= 21'h000000;
      reg_rd_addr <= 24'h000000;
    end else if (!cs_act) begin
      wr_addr_r <= 21'h000000;                                         // see R23
    end else if (byte_done && state_r == ST_ADDR) begin
      addr_r <= {addr_r[15:0], sh_nxt};
      if (abyte_r == `ADDR_LAST_BYTE) begin
        // top three bits are don't care
        wr_addr_r   <= {addr_r[12:0], sh_nxt};                         // see R8
        // the non-volatile twin reads back through the volatile copy
        reg_rd_addr <= {`REG_VOL_PAGE, addr_r[7:0], sh_nxt};           // see R4
      end
    end else if (byte_done && state_r == ST_WDATA && write_enable_latch) begin
      // wraps from the top address to zero by width, see R19
      wr_addr_r <= wr_addr_r + 21'h000001;                             // see R18 R22
    end
  end
  // write commit: only whole bytes, latch set, outside protection
  always_ff @(posedge clk) begin
    if (reset) begin
      wch.valid <= 1'b0;
      wch.addr  <= 21'h000000;
      wch.data  <= 8'h00;
    end else begin
      // the latch is only read, never cleared here, see R21
      wch.valid <= byte_done && state_r == ST_WDATA && write_enable_latch &&  // see R20
                   !is_protected(wr_addr_r);                           // see R10 R11
      wch.addr  <= wr_addr_r;
      wch.data  <= sh_nxt;                                             // see R12
    end
  end
  // the stream cannot be held off, so a refused byte is reported instead
  always_ff @(posedge clk) begin
    if (reset) begin
      write_dropped <= 1'b0;
    end else begin
      write_dropped <= wch.valid && !wch.ready;                        // see R6
    end
  end
  // register byte out on falling edges; later bytes shift zeros, undefined
  always_ff @(posedge clk) begin
    if (reset || !cs_act) begin
      io_out      <= 4'h0;
      io_oe       <= 4'h0;
      out_sh_r    <= 8'h00;
      first_out_r <= 1'b1;
    end else if (state_r == ST_RDOUT && sck_fall) begin
      first_out_r <= 1'b0;
      case (w_r)
        `LANES_4: begin
          io_out   <= rd_src[7:4];
          io_oe    <= 4'hF;
          out_sh_r <= {rd_src[3:0], 4'h0};                             // see R3
        end
        `LANES_2: begin
          io_out   <= {2'h0, rd_src[7:6]};
          io_oe    <= 4'h3;
          out_sh_r <= {rd_src[5:0], 2'h0};
        end
        default: begin
          io_out   <= {2'h0, rd_src[7], 1'b0};                         // see R1
          io_oe    <= 4'h2;
          out_sh_r <= {rd_src[6:0], 1'b0};
        end
      endcase
    end
  end
  // status outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      busy       <= 1'b0;
      xip_active <= 1'b0;
    end else begin
      busy       <= cs_act;
      xip_active <= xip_r;
    end
  end
  // two-entry buffer between the decoder and the array port
  wr_buf u_buf (
    .clk       (clk),
    .reset     (reset),
    .in_ch     (wch),
    .out_valid (mem_wr_valid),
    .out_ready (mem_wr_ready),
    .out_addr  (mem_wr_addr),
    .out_data  (mem_wr_data)
  );
endmodule

// File: fram_cmd_assertions.sv
// concurrent checks on the command front end ports
`timescale 1ns/1ns
module fram_cmd_assertions (
  input wire logic        clk,                // clock
  input wire logic        reset,              // sync reset
  input wire logic        cs_n,               // select
  input wire logic [3:0]  io_oe,              // enables
  input wire logic        write_enable_latch, // latch
  input wire logic        protect_en,         // protect on
  input wire logic [20:0] protect_lo,         // window low
  input wire logic [20:0] protect_hi,         // window high
  input wire logic        mem_wr_valid,       // request
  input wire logic        mem_wr_ready,       // taken
  input wire logic [20:0] mem_wr_addr,        // address
  input wire logic [7:0]  mem_wr_data,        // data
  input wire logic        write_dropped,      // lost byte
  input wire logic        busy                // select seen
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // a request the array has not taken yet
  sequence s_stalled;
    mem_wr_valid && !mem_wr_ready;
  endsequence
  // the same request still offered
  sequence s_held;
    mem_wr_valid && $stable(mem_wr_addr) && $stable(mem_wr_data);
  endsequence
  a_req_holds: assert property (s_stalled |=> s_held)
    else $error("write request changed before taken");
  a_no_prot_write: assert property (mem_wr_valid && protect_en |->
    !(mem_wr_addr >= protect_lo && mem_wr_addr <= protect_hi))
    else $error("write issued inside protected window");
  // latch low now and eight cycles back, with no request out, means no request next cycle
  a_latch_gates: assert property (!write_enable_latch && !mem_wr_valid &&
    $past(!write_enable_latch, 8) |=> !mem_wr_valid)
    else $error("write issued with latch low");
  a_oe_idle: assert property (cs_n [*8] |-> io_oe == 4'h0)
    else $error("lines driven while deselected");
  a_oe_width: assert property (io_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
    else $error("illegal lane enable set");
  a_busy_rise: assert property ($fell(cs_n) |-> ##[1:5] busy)
    else $error("select not seen");
  a_busy_drop: assert property ($rose(cs_n) |-> ##[1:5] !busy)
    else $error("frame not ended by select high");
  a_drop_pulse: assert property (write_dropped |=> !write_dropped)
    else $error("drop flag longer than one cycle");
endmodule

// File: host_spi_model.sv
// host serial controller model: select, link clock and data lines
`timescale 1ns/1ns
module host_spi_model (
  output logic            cs_n,  // select, active low
  output logic            sck,   // link clock, idle low
  output logic      [3:0] io_in, // lines toward the device
  input  wire logic [3:0] io_out // device output lines
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    io_in = 4'h0;
  end
  // settle gap before the first edge so the device sync sees select
  task open_frame();
    cs_n = 1'b0;
    #160;
  endtask
  // bits msb first over w lines, changed while the clock is low
  task put(input logic [7:0] b, input int w, input int nbits = 8);
    for (int i = 0; i < nbits; i += w) begin
      for (int k = 0; k < w; k++) io_in[w-1-k] = b[7-i-k];
      #160 sck = 1'b1;
      #160 sck = 1'b0;
    end
  endtask
  // released lines show the inverse, never a held copy
  task close_frame();
    #160 cs_n = 1'b1;
    io_in = ~io_in;
    #480;
  endtask
  // dummy clocks, then one byte read late in each high phase
  task get(input int dummies, output logic [7:0] b);
    repeat (dummies) begin
      #160 sck = 1'b1;
      #160 sck = 1'b0;
    end
    for (int i = 7; i >= 0; i--) begin
      #160 sck = 1'b1;
      #150 b[i] = io_out[1];
      #10 sck = 1'b0;
    end
  endtask
endmodule

// File: tb_top.sv
// top testbench for the command front end
`timescale 1ns/1ns
module tb_top;
  typedef struct {logic [7:0] op; int wo; int wa; int wd; bit md; logic [1:0] wide;
    logic [23:0] a; logic [7:0] m;} row_t;
  logic clk = 1'b0, reset = 1'b1, cs_n, sck, busy, xip_active, write_dropped;
  logic [3:0] io_in, io_out, io_oe;
  logic dual_wide_mode = 1'b0, quad_wide_mode = 1'b0, write_enable_latch = 1'b1;
  logic [7:0] latency_config_reg = 8'h02; // two dummy cycles
  logic protect_en = 1'b0;
  logic [20:0] protect_lo = 21'h000100, protect_hi = 21'h000101, mem_wr_addr;
  logic [23:0] reg_rd_addr;
  logic [7:0] reg_rd_data = 8'hC3, mem_wr_data, b;
  logic mem_wr_valid, mem_wr_ready = 1'b0, stall = 1'b0, drop_seen = 1'b0;
  logic [28:0] q[$]; // takes seen at the array side
  int errors = 0, num_checks = 0, cyc = 0;
  row_t r;
  row_t rows[9] = '{'{8'h02, 1, 1, 1, 0, 2'h0, 24'h000010, 8'h00},
    '{8'h02, 2, 2, 2, 0, 2'h1, 24'h000020, 8'h00}, '{8'h02, 4, 4, 4, 0, 2'h2, 24'h000030, 8'h00},
    '{8'hDA, 1, 1, 1, 1, 2'h0, 24'h000040, 8'h00}, '{8'hA2, 1, 1, 2, 1, 2'h0, 24'h000050, 8'h00},
    '{8'hA1, 1, 2, 2, 1, 2'h0, 24'h000060, 8'h00}, '{8'h32, 1, 1, 4, 1, 2'h0, 24'h000070, 8'h00},
    '{8'hD2, 1, 4, 4, 1, 2'h0, 24'h000080, 8'h00}, '{8'h02, 1, 1, 1, 0, 2'h0, 24'hFFFFFF, 8'h00}};
  always #20 clk = ~clk;
  fram_cmd fram_cmd_inst (.clk, .reset, .cs_n, .sck, .io_in, .io_out, .io_oe, .dual_wide_mode,
    .quad_wide_mode, .write_enable_latch, .latency_config_reg, .protect_en, .protect_lo,
    .protect_hi, .reg_rd_addr, .reg_rd_data, .mem_wr_valid, .mem_wr_ready, .mem_wr_addr,
    .mem_wr_data, .write_dropped, .xip_active, .busy);
  host_spi_model host_spi_model_inst (.cs_n, .sck, .io_in, .io_out);
  // array side: log takes, ready two cycles on and two off so the buffer sees stalls
  always @(posedge clk) begin
    if (mem_wr_valid && mem_wr_ready) q.push_back({mem_wr_addr, mem_wr_data});
    if (write_dropped) drop_seen = 1'b1;
    #1 cyc++;
    mem_wr_ready = !stall && cyc[1];
  end
  task chk(input logic [28:0] s, input logic [28:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task final_report();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one write frame; skip leaves out the opcode, tail adds a cut byte
  task wr_frame(input row_t x, input int n, input bit skip, input int tail);
    host_spi_model_inst.open_frame();
    if (!skip) host_spi_model_inst.put(x.op, x.wo);
    for (int j = 2; j >= 0; j--) host_spi_model_inst.put(x.a[8*j +: 8], x.wa);
    if (x.md) host_spi_model_inst.put(x.m, x.wa);
    for (int j = 0; j < n; j++) host_spi_model_inst.put(8'h3C + 8'(j), x.wd);
    if (tail > 0) host_spi_model_inst.put(8'hFF, x.wd, tail);
    host_spi_model_inst.close_frame();
  endtask
  // bounded wait for n takes with the block idle
  task settle(input int n);
    int i;
    for (i = 0; i < 800 && !(q.size() >= n && !busy && !mem_wr_valid); i++) @(posedge clk);
    if (i == 800) begin
      errors++;
      final_report();
    end
    #1 chk(q.size(), n);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #1 reset = 1'b0;
    chk({busy, xip_active, mem_wr_valid, io_oe}, 29'h0);
    repeat (3) @(posedge clk);
    foreach (rows[i]) begin
      r = rows[i];
      {quad_wide_mode, dual_wide_mode} = r.wide;
      q.delete();
      wr_frame(r, 2, 0, 0);
      settle(2);
      for (int k = 0; k < 2; k++) chk(q[k], {r.a[20:0] + 21'(k), 8'h3C + 8'(k)});
    end
    r = rows[0];
    q.delete();
    write_enable_latch = 1'b0;
    wr_frame(r, 2, 0, 0);
    settle(0);
    write_enable_latch = 1'b1;
    protect_en = 1'b1;
    r.a = 24'h0000FF;
    wr_frame(r, 4, 0, 0);
    settle(2);
    chk(q[1], {21'h000102, 8'h3F});
    q.delete();
    r.a = 24'h000100;
    wr_frame(r, 3, 0, 0);
    settle(1);
    chk(q[0], {21'h000102, 8'h3E});
    protect_en = 1'b0;
    q.delete();
    wr_frame(r, 1, 0, 4);
    settle(1);
    q.delete();
    stall = 1'b1;
    drop_seen = 1'b0;
    wr_frame(r, 3, 0, 0);
    chk(drop_seen, 1'b1);
    stall = 1'b0;
    settle(2);
    host_spi_model_inst.open_frame();
    for (int j = 0; j < 4; j++) host_spi_model_inst.put(8'(32'h65000006 >> (24 - 8 * j)), 1);
    host_spi_model_inst.get(2, b);
    chk(reg_rd_addr, 24'h070006);
    chk(b, 8'hC3);
    chk(io_oe, 4'h2);
    host_spi_model_inst.close_frame();
    r = rows[3];
    r.m = 8'hA0;
    q.delete();
    wr_frame(r, 1, 0, 0);
    chk(xip_active, 1'b1);
    r.a = 24'h000410;
    r.m = 8'h00;
    wr_frame(r, 1, 1, 0);
    settle(2);
    chk(q[1], {21'h000410, 8'h3C});
    chk(xip_active, 1'b0);
    final_report();
  end
endmodule
bind fram_cmd fram_cmd_assertions fram_cmd_assertions_inst (.clk, .reset, .cs_n, .io_oe,
  .write_enable_latch, .protect_en, .protect_lo, .protect_hi, .mem_wr_valid, .mem_wr_ready,
  .mem_wr_addr, .mem_wr_data, .write_dropped, .busy);
